// ---- hdl/pll_ctrl_pkg.sv ----
package pll_ctrl_pkg;

	// register indices as printed, on an 8-bit address port
	localparam logic [7:0] ADDR_LOCK = 8'h07;
	localparam logic [7:0] ADDR_REF_DIV = 8'h19;
	localparam logic [7:0] ADDR_MASH = 8'h1B;
	localparam logic [7:0] ADDR_FB_INT = 8'h1E;
	localparam logic [7:0] ADDR_NUM_LO = 8'h1F;
	localparam logic [7:0] ADDR_NUM_HI = 8'h20;
	localparam logic [7:0] ADDR_DEN_LO = 8'h21;
	localparam logic [7:0] ADDR_DEN_HI = 8'h22;
	localparam logic [7:0] ADDR_SSC_EN = 8'h29;
	localparam logic [7:0] ADDR_SSC_CFG = 8'h2A;
	localparam logic [7:0] ADDR_LOCK_WIN = 8'h32;
	localparam logic [7:0] ADDR_PFD_CFG = 8'h33;

	// field positions
	localparam int LIVE_LOCK_BIT = 0;
	localparam int STICKY_BIT = 1;
	localparam int SSC_EN_BIT = 15;
	localparam int SSC_TYPE_BIT = 5;
	localparam int SSC_SEL_LSB = 1;
	localparam int LOCK_WIN_LSB = 8;
	localparam int PFD_SE_BIT = 6;
	localparam int FRAC_BIT = 10;

	// values after reset, plus the last spread preset code
	localparam logic [7:0] REF_DIV_RST = 8'h01;
	localparam logic [14:0] FB_INT_RST = 15'h0060;
	localparam logic [23:0] FRAC_RST = 24'h000000;
	localparam logic [2:0] LOCK_WIN_RST = 3'h0;
	localparam logic [24:0] DEN_FULL = 25'h1000000;
	localparam logic [2:0] SSC_SEL_LAST = 3'h3;

	// timing
	localparam longint CLK_HZ = 200_000_000;
	localparam longint MOD_RATE_DECI_HZ = 315_000;
	localparam int MOD_PERIOD_CYCLES = int'((CLK_HZ * 10) / MOD_RATE_DECI_HZ);
	localparam int TRI_STEPS = 64;
	localparam int TRI_SHIFT = 6;

	typedef enum logic [1:0] {
		RAMP_UP = 2'b01,
		RAMP_DOWN = 2'b10
	} ramp_e;

	// everything the analog loop reads
	typedef struct packed {
		logic [7:0] ref_div;
		logic ref_double;
		logic [14:0] feedback_integer_value;
		logic signed [35:0] num_eff;
		logic [24:0] den_used;
		logic [1:0] mash_order;
		logic pfd_single_ended;
		logic frac_mode;
		logic [2:0] lock_window;
	} loop_ctrl_s;

endpackage : pll_ctrl_pkg

// ---- hdl/pll_ctrl.sv ----
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - detector rate is input over divider, zero doubles
// - integer feedback value from 15-bit field
// - numerator is upper 8 and lower 16 bits
// - denominator likewise, zero means two to 24
// - modulator order zero integer, 1-3 MASH order
// - live lock bit, also driven to pin
// - sticky bit catches any loss of lock
// - spread disabled means no modulation at all
// - spread type zero down, one center
// - spread select picks preset, 4-7 unused
// - deviation follows a triangle over time
// - modulation on synthesized clocks, bypass untouched
// - preset modulation rate is 31.5 kHz; step rounding gives 6272 cycles at 200 MHz, about 31.9 kHz
module pll_ctrl #(
	parameter int MOD_PERIOD_CYCLES = pll_ctrl_pkg::MOD_PERIOD_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// analog loop
	input wire logic loop_locked,
	output pll_ctrl_pkg::loop_ctrl_s loop_ctrl,
	output logic lock_gpio
);

	localparam int STEP_CYCLES = MOD_PERIOD_CYCLES / (2 * pll_ctrl_pkg::TRI_STEPS);
	localparam logic [12:0] STEP_LAST = 13'(STEP_CYCLES - 1);
	localparam logic [6:0] TRI_TOP = 7'(pll_ctrl_pkg::TRI_STEPS);

	typedef struct packed {
		pll_ctrl_pkg::loop_ctrl_s ctrl;
		logic [23:0] num;
		logic [23:0] den;
		logic ssc_en;
		logic ssc_type;
		logic [2:0] ssc_sel;
		logic lock_meta;
		logic lock_sync;
		logic lock_live;
		logic sticky_loss;
		logic [15:0] rdata;
		logic [12:0] step_cnt;
		logic [6:0] tri_pos;
		pll_ctrl_pkg::ramp_e ramp;
		logic [31:0] depth;
	} state_s;

	state_s s_q;
	state_s s_d;

	// full deviation in numerator units: 0.25% or 0.5% of N times den
	function automatic logic [31:0] spread_depth(input logic [14:0] n,
			input logic [24:0] den, input logic [2:0] sel);
		logic [39:0] prod;
		logic [39:0] q;
		prod = 40'(n) * 40'(den);
		q = sel[0] ? prod / 40'hC8 : prod / 40'h190;
		spread_depth = q[31:0];
	endfunction : spread_depth

	function automatic logic [24:0] den_of(input logic [23:0] raw);
		den_of = (raw == 24'h000000) ? pll_ctrl_pkg::DEN_FULL : {1'b0, raw};
	endfunction : den_of

	logic wr_hit_lock;
	logic ssc_active;
	logic step_tick;
	logic [38:0] scaled;
	logic signed [35:0] offset;

	always_comb begin
		wr_hit_lock = reg_write && (reg_addr == pll_ctrl_pkg::ADDR_LOCK);
		// codes 4-7 are not presets; treat as unmodulated
		ssc_active = s_q.ssc_en && (s_q.ssc_sel <= pll_ctrl_pkg::SSC_SEL_LAST);
		step_tick = (s_q.step_cnt == STEP_LAST);
		scaled = 39'(s_q.depth) * 39'(s_q.tri_pos);
		if (!ssc_active) begin
			offset = '0;
		end else if (s_q.ssc_type) begin
			// center: +depth .. -depth
			offset = 36'(s_q.depth) - 36'(scaled >> (pll_ctrl_pkg::TRI_SHIFT - 1));
		end else begin
			// down: 0 .. -depth
			offset = -36'(scaled >> pll_ctrl_pkg::TRI_SHIFT);
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = 16'h0000;

		// lock input crosses from the analog loop
		s_d.lock_meta = loop_locked;
		s_d.lock_sync = s_q.lock_meta;
		s_d.lock_live = s_q.lock_sync;
		if (wr_hit_lock && reg_wdata[pll_ctrl_pkg::STICKY_BIT]) begin
			s_d.sticky_loss = 1'b0;
		end
		// a loss in the clearing cycle still lands
		if (s_q.lock_live && !s_q.lock_sync) begin
			s_d.sticky_loss = 1'b1;
		end

		if (reg_write) begin
			unique case (reg_addr)
				pll_ctrl_pkg::ADDR_REF_DIV: begin
					s_d.ctrl.ref_div = reg_wdata[7:0];
					s_d.ctrl.ref_double = (reg_wdata[7:0] == 8'h00);
				end
				pll_ctrl_pkg::ADDR_MASH: begin
					s_d.ctrl.mash_order = reg_wdata[1:0];
				end
				pll_ctrl_pkg::ADDR_FB_INT: begin
					s_d.ctrl.feedback_integer_value = reg_wdata[14:0];
				end
				pll_ctrl_pkg::ADDR_NUM_LO: begin
					s_d.num[15:0] = reg_wdata;
				end
				pll_ctrl_pkg::ADDR_NUM_HI: begin
					s_d.num[23:16] = reg_wdata[7:0];
				end
				pll_ctrl_pkg::ADDR_DEN_LO: begin
					s_d.den[15:0] = reg_wdata;
				end
				pll_ctrl_pkg::ADDR_DEN_HI: begin
					s_d.den[23:16] = reg_wdata[7:0];
				end
				pll_ctrl_pkg::ADDR_SSC_EN: begin
					s_d.ssc_en = reg_wdata[pll_ctrl_pkg::SSC_EN_BIT];
				end
				pll_ctrl_pkg::ADDR_SSC_CFG: begin
					s_d.ssc_type = reg_wdata[pll_ctrl_pkg::SSC_TYPE_BIT];
					s_d.ssc_sel = reg_wdata[pll_ctrl_pkg::SSC_SEL_LSB +: 3];
				end
				pll_ctrl_pkg::ADDR_LOCK_WIN: begin
					// widening is software's job when spreading
					s_d.ctrl.lock_window = reg_wdata[pll_ctrl_pkg::LOCK_WIN_LSB +: 3];
				end
				pll_ctrl_pkg::ADDR_PFD_CFG: begin
					// passed through as written; mode pairing is software's
					s_d.ctrl.pfd_single_ended = reg_wdata[pll_ctrl_pkg::PFD_SE_BIT];
					s_d.ctrl.frac_mode = reg_wdata[pll_ctrl_pkg::FRAC_BIT];
				end
				default: begin
				end
			endcase
		end
		s_d.ctrl.den_used = den_of(s_d.den);

		if (reg_read) begin
			unique case (reg_addr)
				pll_ctrl_pkg::ADDR_LOCK: begin
					s_d.rdata[pll_ctrl_pkg::LIVE_LOCK_BIT] = s_q.lock_live;
					s_d.rdata[pll_ctrl_pkg::STICKY_BIT] = s_q.sticky_loss;
				end
				pll_ctrl_pkg::ADDR_REF_DIV: begin
					s_d.rdata[7:0] = s_q.ctrl.ref_div;
				end
				pll_ctrl_pkg::ADDR_MASH: begin
					s_d.rdata[1:0] = s_q.ctrl.mash_order;
				end
				pll_ctrl_pkg::ADDR_FB_INT: begin
					s_d.rdata[14:0] = s_q.ctrl.feedback_integer_value;
				end
				pll_ctrl_pkg::ADDR_NUM_LO: begin
					s_d.rdata = s_q.num[15:0];
				end
				pll_ctrl_pkg::ADDR_NUM_HI: begin
					s_d.rdata[7:0] = s_q.num[23:16];
				end
				pll_ctrl_pkg::ADDR_DEN_LO: begin
					s_d.rdata = s_q.den[15:0];
				end
				pll_ctrl_pkg::ADDR_DEN_HI: begin
					s_d.rdata[7:0] = s_q.den[23:16];
				end
				pll_ctrl_pkg::ADDR_SSC_EN: begin
					s_d.rdata[pll_ctrl_pkg::SSC_EN_BIT] = s_q.ssc_en;
				end
				pll_ctrl_pkg::ADDR_SSC_CFG: begin
					s_d.rdata[pll_ctrl_pkg::SSC_TYPE_BIT] = s_q.ssc_type;
					s_d.rdata[pll_ctrl_pkg::SSC_SEL_LSB +: 3] = s_q.ssc_sel;
				end
				pll_ctrl_pkg::ADDR_LOCK_WIN: begin
					s_d.rdata[pll_ctrl_pkg::LOCK_WIN_LSB +: 3] = s_q.ctrl.lock_window;
				end
				pll_ctrl_pkg::ADDR_PFD_CFG: begin
					s_d.rdata[pll_ctrl_pkg::PFD_SE_BIT] = s_q.ctrl.pfd_single_ended;
					s_d.rdata[pll_ctrl_pkg::FRAC_BIT] = s_q.ctrl.frac_mode;
				end
				default: begin
				end
			endcase
		end

		// depth follows the config; a division per cycle is pipelined once
		s_d.depth = spread_depth(s_q.ctrl.feedback_integer_value,
			s_q.ctrl.den_used, s_q.ssc_sel);

		// triangle sweep: 2 x TRI_STEPS ticks per modulation period
		if (!ssc_active) begin
			s_d.step_cnt = 13'h0000;
			s_d.tri_pos = 7'h00;
			s_d.ramp = pll_ctrl_pkg::RAMP_UP;
		end else begin
			s_d.step_cnt = step_tick ? 13'h0000 : s_q.step_cnt + 13'h0001;
			if (step_tick) begin
				unique case (s_q.ramp)
					pll_ctrl_pkg::RAMP_UP: begin
						s_d.tri_pos = s_q.tri_pos + 7'h01;
						if (s_q.tri_pos == TRI_TOP - 7'h01) begin
							s_d.ramp = pll_ctrl_pkg::RAMP_DOWN;
						end
					end
					pll_ctrl_pkg::RAMP_DOWN: begin
						s_d.tri_pos = s_q.tri_pos - 7'h01;
						if (s_q.tri_pos == 7'h01) begin
							s_d.ramp = pll_ctrl_pkg::RAMP_UP;
						end
					end
				endcase
			end
		end

		// only the synthesizer fraction is swept; bypass paths never see it
		s_d.ctrl.num_eff = 36'(s_q.num) + offset;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.ctrl.ref_div <= pll_ctrl_pkg::REF_DIV_RST;
			s_q.ctrl.feedback_integer_value <= pll_ctrl_pkg::FB_INT_RST;
			s_q.ctrl.den_used <= pll_ctrl_pkg::DEN_FULL;
			s_q.ctrl.lock_window <= pll_ctrl_pkg::LOCK_WIN_RST;
			s_q.num <= pll_ctrl_pkg::FRAC_RST;
			s_q.den <= pll_ctrl_pkg::FRAC_RST;
			s_q.ramp <= pll_ctrl_pkg::RAMP_UP;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign loop_ctrl = s_q.ctrl;
	assign lock_gpio = s_q.lock_live;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_wr(logic [7:0] a);
		reg_write && reg_addr == a;
	endsequence

	property p_doubler;
		s_wr(pll_ctrl_pkg::ADDR_REF_DIV) ##0 reg_wdata[7:0] == 8'h00
			|=> loop_ctrl.ref_double && loop_ctrl.ref_div == 8'h00;
	endproperty
	a_doubler: assert property (p_doubler)
		else $error("zero divider did not select doubler");

	property p_fb_int;
		s_wr(pll_ctrl_pkg::ADDR_FB_INT)
			|=> loop_ctrl.feedback_integer_value == $past(reg_wdata[14:0]);
	endproperty
	a_fb_int: assert property (p_fb_int)
		else $error("feedback integer value not taken");

	property p_num_hi;
		s_wr(pll_ctrl_pkg::ADDR_NUM_HI) |=> s_q.num[23:16] == $past(reg_wdata[7:0])
			##1 loop_ctrl.num_eff[23:16] == $past(reg_wdata[7:0], 2) || ssc_active;
	endproperty
	a_num_hi: assert property (p_num_hi)
		else $error("numerator upper byte wrong");

	property p_den_zero;
		s_wr(pll_ctrl_pkg::ADDR_DEN_LO) ##0 reg_wdata == 16'h0000
			##0 s_q.den[23:16] == 8'h00 |=> loop_ctrl.den_used == 25'h1000000;
	endproperty
	a_den_zero: assert property (p_den_zero)
		else $error("zero denominator not full scale");

	property p_mash;
		s_wr(pll_ctrl_pkg::ADDR_MASH) |=> loop_ctrl.mash_order == $past(reg_wdata[1:0]);
	endproperty
	a_mash: assert property (p_mash)
		else $error("modulator order not taken");

	sequence s_lock_held;
		loop_locked [*4];
	endsequence

	property p_live;
		s_lock_held |-> lock_gpio && s_q.lock_live;
	endproperty
	a_live: assert property (p_live)
		else $error("live lock not shown three cycles after lock");

	property p_sticky;
		$fell(s_q.lock_live) |-> s_q.sticky_loss;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("loss of lock not caught");

	property p_sticky_hold;
		s_q.sticky_loss && !wr_hit_lock |=> s_q.sticky_loss;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold)
		else $error("sticky bit dropped without clear");

	property p_no_mod;
		!ssc_active [*2] |-> s_q.tri_pos == 7'h00 ##1 loop_ctrl.num_eff == 36'($past(s_q.num));
	endproperty
	a_no_mod: assert property (p_no_mod)
		else $error("modulation while spread disabled");

	property p_triangle;
		!$stable(s_q.tri_pos) && $past(ssc_active) |->
			(s_q.tri_pos == $past(s_q.tri_pos) + 7'h01) ||
			(s_q.tri_pos == $past(s_q.tri_pos) - 7'h01);
	endproperty
	a_triangle: assert property (p_triangle)
		else $error("triangle stepped by more than one");

	property p_rate;
		ssc_active && step_tick |=> s_q.step_cnt == 13'h0000 || !ssc_active;
	endproperty
	a_rate: assert property (p_rate)
		else $error("step divider did not wrap");

	property p_bound;
		s_q.tri_pos <= TRI_TOP;
	endproperty
	a_bound: assert property (p_bound)
		else $error("triangle beyond peak");

endmodule : pll_ctrl

// ---- dv/loop_model.sv ----
`timescale 1ns/1ps

module loop_model (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// loop settings from the block, lock back to it
	input wire pll_ctrl_pkg::loop_ctrl_s loop_ctrl,
	input wire logic lose,
	output logic loop_locked
);
	localparam int RELOCK = 20;
	logic [25:0] key_q;
	int cnt_q;
	// spread moves num_eff all the time, so only divider, feedback integer and modulator order changes (or lose) drop lock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= RELOCK;
			key_q <= '0;
		end else begin
			key_q <= {loop_ctrl.ref_div, loop_ctrl.ref_double,
				loop_ctrl.feedback_integer_value, loop_ctrl.mash_order};
			if (key_q != {loop_ctrl.ref_div, loop_ctrl.ref_double,
				loop_ctrl.feedback_integer_value, loop_ctrl.mash_order})
				cnt_q <= RELOCK;
			else if (cnt_q != 0)
				cnt_q <= cnt_q - 1;
		end
	end
	assign loop_locked = (cnt_q == 0) && !lose;
endmodule : loop_model

// ---- dv/frac_n_pll_control_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); \
	end \
end

module frac_n_pll_control_tb_top;
	localparam int MODP = 256;
	logic clock;
	logic reset_n;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [15:0] reg_rdata;
	logic lose;
	logic loop_locked;
	logic lock_gpio;
	pll_ctrl_pkg::loop_ctrl_s loop_ctrl;
	int n_errors;
	int checks_done;
	logic [15:0] v;
	logic signed [35:0] nm;

	pll_ctrl #(.MOD_PERIOD_CYCLES(MODP)) dut (.clock(clock),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.loop_locked(loop_locked), .loop_ctrl(loop_ctrl),
		.lock_gpio(lock_gpio));
	loop_model partner (.clock(clock), .reset_n(reset_n),
		.loop_ctrl(loop_ctrl), .lose(lose), .loop_locked(loop_locked));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// min, max and the spacing of departures from the bare numerator
	task automatic sweep(output logic signed [35:0] mn,
		output logic signed [35:0] mx, output int per);
		int t0;
		logic eq;
		logic eq_q;
		logic signed [35:0] n;
		t0 = -1;
		per = 0;
		eq_q = 1'b0;
		mn = nm;
		mx = nm;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 600; i++) begin
			@(posedge clock);
			#1;
			n = $signed(loop_ctrl.num_eff);
			eq = (n === nm);
			if (eq_q && !eq) begin
				if (t0 >= 0)
					per = i - t0;
				t0 = i;
			end
			eq_q = eq;
			if (n < mn)
				mn = n;
			if (n > mx)
				mx = n;
		end
	endtask : sweep

	task automatic t_cfg();
		`CHK(loop_ctrl.ref_div, pll_ctrl_pkg::REF_DIV_RST)
		`CHK(loop_ctrl.den_used, pll_ctrl_pkg::DEN_FULL)
		wr(pll_ctrl_pkg::ADDR_REF_DIV, 16'h0000);
		`CHK({loop_ctrl.ref_double, loop_ctrl.ref_div}, 9'h100)
		wr(pll_ctrl_pkg::ADDR_REF_DIV, 16'h00FF);
		`CHK({loop_ctrl.ref_double, loop_ctrl.ref_div}, 9'h0FF)
		wr(pll_ctrl_pkg::ADDR_FB_INT, 16'hFFFF);
		`CHK(loop_ctrl.feedback_integer_value, 15'h7FFF)
		wr(pll_ctrl_pkg::ADDR_NUM_HI, 16'hFFAB);
		wr(pll_ctrl_pkg::ADDR_NUM_LO, 16'h1234);
		`CHK($signed(loop_ctrl.num_eff), nm)
		wr(pll_ctrl_pkg::ADDR_DEN_HI, 16'h0001);
		`CHK(loop_ctrl.den_used, 25'h0010000)
		wr(pll_ctrl_pkg::ADDR_DEN_HI, 16'h0000);
		`CHK(loop_ctrl.den_used, pll_ctrl_pkg::DEN_FULL)
		wr(pll_ctrl_pkg::ADDR_DEN_LO, 16'h0005);
		`CHK(loop_ctrl.den_used, 25'h0000005)
		wr(pll_ctrl_pkg::ADDR_DEN_LO, 16'h0000);
		`CHK(loop_ctrl.den_used, pll_ctrl_pkg::DEN_FULL)
		wr(pll_ctrl_pkg::ADDR_PFD_CFG, 16'h0040);
		`CHK({loop_ctrl.pfd_single_ended, loop_ctrl.frac_mode}, 2'b10)
		for (int m = 0; m < 4; m++) begin
			wr(pll_ctrl_pkg::ADDR_MASH, 16'(m));
			`CHK(loop_ctrl.mash_order, 2'(m))
		end
		wr(pll_ctrl_pkg::ADDR_PFD_CFG, 16'h0400);
		`CHK({loop_ctrl.pfd_single_ended, loop_ctrl.frac_mode}, 2'b01)
		$display("test config done");
	endtask : t_cfg

	task automatic t_lock();
		repeat (30) @(posedge clock);
		wr(pll_ctrl_pkg::ADDR_LOCK, 16'h0002);
		rd(pll_ctrl_pkg::ADDR_LOCK, v);
		`CHK(v, 16'h0001)
		@(posedge clock);
		lose <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		`CHK(lock_gpio, 1'b1)
		@(posedge clock);
		#1;
		`CHK(lock_gpio, 1'b0)
		rd(pll_ctrl_pkg::ADDR_LOCK, v);
		`CHK(v, 16'h0002)
		lose <= 1'b0;
		repeat (6) @(posedge clock);
		rd(pll_ctrl_pkg::ADDR_LOCK, v);
		`CHK(v, 16'h0003)
		wr(pll_ctrl_pkg::ADDR_LOCK, 16'h0001);
		rd(pll_ctrl_pkg::ADDR_LOCK, v);
		`CHK(v, 16'h0003)
		wr(pll_ctrl_pkg::ADDR_LOCK, 16'h0002);
		rd(pll_ctrl_pkg::ADDR_LOCK, v);
		`CHK(v, 16'h0001)
		$display("test lock done");
	endtask : t_lock

	task automatic t_ssc();
		logic signed [35:0] mn;
		logic signed [35:0] mx;
		logic signed [35:0] d;
		int per;
		wr(pll_ctrl_pkg::ADDR_LOCK_WIN, 16'h0700);
		// 25 MHz input straight through keeps the detector on a preset rate
		wr(pll_ctrl_pkg::ADDR_REF_DIV, 16'h0001);
		wr(pll_ctrl_pkg::ADDR_FB_INT, 16'h0060);
		wr(pll_ctrl_pkg::ADDR_SSC_EN, 16'h8000);
		for (int t = 0; t < 2; t++) begin
			for (int s = 0; s < 4; s++) begin
				wr(pll_ctrl_pkg::ADDR_SSC_CFG, 16'(t * 32 + s * 2));
				d = (36'sh60 <<< 24) / ((s % 2) ? 200 : 400);
				sweep(mn, mx, per);
				`CHK(mn, nm - d)
				`CHK(mx, (t == 1) ? nm + d : nm)
				if (t == 0)
					`CHK(per, MODP)
			end
		end
		`CHK({loop_ctrl.ref_double, loop_ctrl.ref_div, loop_ctrl.den_used}, {1'b0, 8'h01, pll_ctrl_pkg::DEN_FULL})
		wr(pll_ctrl_pkg::ADDR_SSC_CFG, 16'h0008);
		sweep(mn, mx, per);
		`CHK({mn, mx}, {nm, nm})
		wr(pll_ctrl_pkg::ADDR_SSC_CFG, 16'h0000);
		wr(pll_ctrl_pkg::ADDR_SSC_EN, 16'h0000);
		sweep(mn, mx, per);
		`CHK({mn, mx}, {nm, nm})
		$display("test spread done");
	endtask : t_ssc

	task automatic t_bad();
		rd(8'h00, v);
		`CHK(v, 16'h0000)
		wr(8'h40, 16'hFFFF);
		rd(8'h40, v);
		`CHK(v, 16'h0000)
		@(posedge clock);
		#1;
		`CHK(reg_rdata, 16'h0000)
		`CHK(loop_ctrl.lock_window, 3'h7)
		rd(pll_ctrl_pkg::ADDR_REF_DIV, v);
		`CHK(v, 16'h0001)
		rd(pll_ctrl_pkg::ADDR_FB_INT, v);
		`CHK(v, 16'h0060)
		rd(pll_ctrl_pkg::ADDR_NUM_HI, v);
		`CHK(v, 16'h00AB)
		rd(pll_ctrl_pkg::ADDR_NUM_LO, v);
		`CHK(v, 16'h1234)
		rd(pll_ctrl_pkg::ADDR_DEN_LO, v);
		`CHK(v, 16'h0000)
		rd(pll_ctrl_pkg::ADDR_MASH, v);
		`CHK(v, 16'h0003)
		rd(pll_ctrl_pkg::ADDR_PFD_CFG, v);
		`CHK(v, 16'h0400)
		rd(pll_ctrl_pkg::ADDR_LOCK_WIN, v);
		`CHK(v, 16'h0700)
		wr(pll_ctrl_pkg::ADDR_SSC_CFG, 16'h002E);
		rd(pll_ctrl_pkg::ADDR_SSC_CFG, v);
		`CHK(v, 16'h002E)
		wr(pll_ctrl_pkg::ADDR_SSC_EN, 16'h8000);
		rd(pll_ctrl_pkg::ADDR_SSC_EN, v);
		`CHK(v, 16'h8000)
		repeat (4) @(posedge clock);
		#1;
		`CHK($signed(loop_ctrl.num_eff), nm)
		wr(pll_ctrl_pkg::ADDR_SSC_EN, 16'h0000);
		$display("test unmapped done");
	endtask : t_bad

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		lose = 1'b0;
		n_errors = 0;
		checks_done = 0;
		nm = 36'sh000AB1234;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		t_cfg();
		t_lock();
		t_ssc();
		t_bad();
		finish_test();
	end

	// the whole run is near 6200 cycles; this is well beyond it
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end
endmodule : frac_n_pll_control_tb_top
